// ### hdl/bitmanip_pkg.sv
// Package: operation codes, carriers and constants of the bit-manipulation unit
package bitmanip_pkg;

   // ==========================================
   // Widths and field positions
   localparam int XLEN_DEFAULT = 64;
   localparam int WORD_BITS = 32;
   localparam int BYTE_BITS = 8;
   localparam int HALF_BITS = 16;
   localparam int BYTE_SIGN_BIT = 7;
   localparam int HALF_SIGN_BIT = 15;
   localparam int WORD_SIGN_BIT = 31;
   localparam int WORD_SHAMT_BITS = 5;
   localparam int IMM_BITS = 6;
   localparam int SHIFT1_AMOUNT = 1;
   localparam int PIPE_LATENCY = 1;
   localparam logic [63:0] RESULT_RESET = 64'h0000_0000_0000_0000;

   // ==========================================
   // Operation select
   typedef enum logic [3:0] {
      OP_PACK_BYTES = 4'h0,
      OP_PACK_HALVES_WORD = 4'h1,
      OP_BYTE_REVERSE = 4'h2,
      OP_BIT_REVERSE_BYTES = 4'h3,
      OP_ROTL = 4'h4,
      OP_ROTL_WORD = 4'h5,
      OP_ROTR = 4'h6,
      OP_ROTR_IMM = 4'h7,
      OP_ROTR_IMM_WORD = 4'h8,
      OP_ROTR_WORD = 4'h9,
      OP_SIGN_EXT_BYTE = 4'ha,
      OP_SIGN_EXT_HALF = 4'hb,
      OP_SHIFT1_ADD = 4'hc,
      OP_SHIFT1_ADD_UW = 4'hd
   } alu_op_e;

   // ==========================================
   // Request and answer carriers
   typedef struct packed {
      logic valid;
      alu_op_e op;
      logic [63:0] first_source;
      logic [63:0] second_source;
      logic [IMM_BITS-1:0] imm;
   } alu_req_s;

   typedef struct packed {
      logic valid;
      logic illegal;
      logic [63:0] result;
   } alu_rsp_s;

endpackage

// ### hdl/word_rotator.sv
// Word-wide rotator with sign-extended result
module word_rotator
   import bitmanip_pkg::*;
(
   input wire logic [WORD_BITS-1:0] word_in,
   input wire logic [WORD_SHAMT_BITS-1:0] amount,
   input wire logic rotate_right,
   output logic [63:0] result
);
   logic [2*WORD_BITS-1:0] doubled;
   logic [WORD_BITS-1:0] rotated;

   // ==========================================
   // Rotate by shifting a doubled copy, so amount zero is a plain pass
   always_comb
   begin
      doubled = {word_in, word_in};
      if (rotate_right)
      begin
         rotated = doubled[amount +: WORD_BITS];
      end
      else
      begin
         rotated = doubled[(WORD_BITS - 32'(amount)) % WORD_BITS +: WORD_BITS];
      end
      result = {{(64-WORD_BITS){rotated[WORD_SIGN_BIT]}}, rotated};
   end
endmodule // word_rotator

// ### hdl/bitmanip_rotate_pack_alu.sv
// Bit-manipulation execution unit: pack, reverse, rotate, sign-extend, shift-add
module bitmanip_rotate_pack_alu
   import bitmanip_pkg::*;
#(
   parameter int XLEN = XLEN_DEFAULT
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire bitmanip_pkg::alu_req_s req,
   output bitmanip_pkg::alu_rsp_s rsp
);
   import bitmanip_pkg::*;

   localparam int SHAMT_BITS = $clog2(XLEN);
   localparam int BYTES = XLEN / BYTE_BITS;

   // ==========================================
   // Elaboration check
   if (XLEN != 32 && XLEN != 64)
   begin : g_bad_xlen
      $error("XLEN must be 32 or 64");
   end

   logic [XLEN-1:0] src_a;
   logic [XLEN-1:0] src_b;
   logic [XLEN-1:0] byte_rev;
   logic [XLEN-1:0] bit_rev;
   logic [2*XLEN-1:0] doubled;
   logic [SHAMT_BITS-1:0] rot_amt;
   logic [XLEN-1:0] rot_full;
   logic [WORD_SHAMT_BITS-1:0] word_amt;
   logic word_right;
   logic [63:0] word_rot;
   logic [XLEN-1:0] result_c;
   logic illegal_c;
   alu_rsp_s rsp_d;
   alu_rsp_s rsp_q;

   assign src_a = req.first_source[XLEN-1:0];
   assign src_b = req.second_source[XLEN-1:0];

   // ==========================================
   // Byte order and in-byte bit order reversal
   for (genvar i = 0; i < BYTES; i++)
   begin : g_bytes
      assign byte_rev[i*BYTE_BITS +: BYTE_BITS] = src_a[(BYTES-1-i)*BYTE_BITS +: BYTE_BITS];
      for (genvar j = 0; j < BYTE_BITS; j++)
      begin : g_bits
         assign bit_rev[i*BYTE_BITS + j] = src_a[i*BYTE_BITS + BYTE_BITS-1-j];
      end
   end

   // ==========================================
   // Full-width rotate amount and rotator
   always_comb
   begin
      doubled = {src_a, src_a};
      if (req.op == OP_ROTR_IMM)
      begin
         rot_amt = req.imm[SHAMT_BITS-1:0];
      end
      else
      begin
         rot_amt = src_b[SHAMT_BITS-1:0];
      end
      if (req.op == OP_ROTL)
      begin
         rot_full = doubled[(XLEN - 32'(rot_amt)) % XLEN +: XLEN];
      end
      else
      begin
         rot_full = doubled[rot_amt +: XLEN];
      end
   end

   // ==========================================
   // Word rotate amount and direction
   always_comb
   begin
      word_right = (req.op != OP_ROTL_WORD);
      if (req.op == OP_ROTR_IMM_WORD)
      begin
         word_amt = req.imm[WORD_SHAMT_BITS-1:0];
      end
      else
      begin
         word_amt = src_b[WORD_SHAMT_BITS-1:0];
      end
   end

   word_rotator u_word_rotator (
      .word_in(src_a[WORD_BITS-1:0]),
      .amount(word_amt),
      .rotate_right(word_right),
      .result(word_rot)
   );

   // ==========================================
   // Result select
   always_comb
   begin
      result_c = '0;
      illegal_c = 1'b0;
      case (req.op)
         OP_PACK_BYTES:
         begin
            result_c[2*BYTE_BITS-1:0] = {src_b[BYTE_BITS-1:0], src_a[BYTE_BITS-1:0]};
         end
         OP_PACK_HALVES_WORD:
         begin
            if (XLEN == 64)
            begin
               result_c = XLEN'({{(64-WORD_BITS){src_b[HALF_BITS-1]}},
                  src_b[HALF_BITS-1:0], src_a[HALF_BITS-1:0]});
            end
            else
            begin
               illegal_c = 1'b1;
            end
         end
         OP_BYTE_REVERSE:
         begin
            result_c = byte_rev;
         end
         OP_BIT_REVERSE_BYTES:
         begin
            result_c = bit_rev;
         end
         OP_ROTL, OP_ROTR:
         begin
            result_c = rot_full;
         end
         OP_ROTR_IMM:
         begin
            result_c = rot_full;
            if (XLEN == 32 && req.imm[IMM_BITS-1])
            begin
               illegal_c = 1'b1;
            end
         end
         OP_ROTL_WORD, OP_ROTR_WORD, OP_ROTR_IMM_WORD:
         begin
            if (XLEN == 64)
            begin
               result_c = word_rot[XLEN-1:0];
            end
            else
            begin
               illegal_c = 1'b1;
            end
         end
         OP_SIGN_EXT_BYTE:
         begin
            result_c = {{(XLEN-BYTE_BITS){src_a[BYTE_SIGN_BIT]}}, src_a[BYTE_SIGN_BIT:0]};
         end
         OP_SIGN_EXT_HALF:
         begin
            result_c = {{(XLEN-HALF_BITS){src_a[HALF_SIGN_BIT]}}, src_a[HALF_SIGN_BIT:0]};
         end
         OP_SHIFT1_ADD:
         begin
            result_c = src_b + (src_a << SHIFT1_AMOUNT);
         end
         OP_SHIFT1_ADD_UW:
         begin
            if (XLEN == 64)
            begin
               result_c = src_b + XLEN'({32'h0000_0000, src_a[WORD_BITS-1:0]} << SHIFT1_AMOUNT);
            end
            else
            begin
               illegal_c = 1'b1;
            end
         end
         default:
         begin
            illegal_c = 1'b1;
         end
      endcase
   end

   // ==========================================
   // Next answer: illegal operations return zero
   always_comb
   begin
      rsp_d.valid = req.valid;
      rsp_d.illegal = req.valid & illegal_c;
      rsp_d.result = '0;
      if (req.valid && !illegal_c)
      begin
         rsp_d.result = 64'(result_c);
      end
   end

   // ==========================================
   // Writeback register
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rsp_q <= '{valid: 1'b0, illegal: 1'b0, result: RESULT_RESET};
      end
      else
      begin
         rsp_q <= rsp_d;
      end
   end

   assign rsp = rsp_q;

   // ==========================================
   // Assertions
   a_pack_bytes_out: assert property (@(posedge clk) disable iff (!rstn)
      $past(req.valid && req.op == OP_PACK_BYTES) |->
      rsp.result == {48'h0, $past(req.second_source[7:0]), $past(req.first_source[7:0])})
      else $error("pack bytes result wrong");

   a_pack_half_word: assert property (@(posedge clk) disable iff (!rstn)
      $past(req.valid && req.op == OP_PACK_HALVES_WORD) |->
      (XLEN == 64 ? rsp.result[31:0] == {$past(req.second_source[15:0]), $past(req.first_source[15:0])}
       && rsp.result[63:32] == {32{rsp.result[31]}} : rsp.illegal))
      else $error("pack halves word wrong");

   a_byte_rev_ends: assert property (@(posedge clk) disable iff (!rstn)
      $past(req.valid && req.op == OP_BYTE_REVERSE) |->
      rsp.result[XLEN-1 -: 8] == $past(req.first_source[7:0]))
      else $error("byte reverse wrong");

   a_bit_rev_low: assert property (@(posedge clk) disable iff (!rstn)
      $past(req.valid && req.op == OP_BIT_REVERSE_BYTES) |->
      rsp.result[0] == $past(req.first_source[7]) && rsp.result[7] == $past(req.first_source[0]))
      else $error("bit reverse wrong");

   a_rotate_zero_same: assert property (@(posedge clk) disable iff (!rstn)
      $past(req.valid && (req.op == OP_ROTL || req.op == OP_ROTR) && req.second_source[5:0] == 6'h00) |->
      rsp.result[XLEN-1:0] == $past(req.first_source[XLEN-1:0]))
      else $error("zero rotate changed value");

   a_rotl_low_bit: assert property (@(posedge clk) disable iff (!rstn)
      $past(req.valid && req.op == OP_ROTL && req.second_source[5:0] == 6'h01) |->
      rsp.result[0] == $past(req.first_source[XLEN-1]))
      else $error("rotate left wrap wrong");

   a_rotr_top_bit: assert property (@(posedge clk) disable iff (!rstn)
      $past(req.valid && req.op == OP_ROTR && req.second_source[5:0] == 6'h01) |->
      rsp.result[XLEN-1] == $past(req.first_source[0]))
      else $error("rotate right wrap wrong");

   a_word_sign_ext: assert property (@(posedge clk) disable iff (!rstn)
      $past(req.valid && (req.op == OP_ROTL_WORD || req.op == OP_ROTR_WORD || req.op == OP_ROTR_IMM_WORD))
      && XLEN == 64 |-> rsp.result[63:32] == {32{rsp.result[31]}})
      else $error("word rotate not sign-extended");

   a_sext_byte_out: assert property (@(posedge clk) disable iff (!rstn)
      $past(req.valid && req.op == OP_SIGN_EXT_BYTE) |->
      rsp.result[XLEN-1:0] == XLEN'($signed($past(req.first_source[7:0]))))
      else $error("byte sign extension wrong");

   a_shift1_add_sum: assert property (@(posedge clk) disable iff (!rstn)
      $past(req.valid && req.op == OP_SHIFT1_ADD) |->
      rsp.result[XLEN-1:0] == XLEN'($past(req.second_source[XLEN-1:0]) + ($past(req.first_source[XLEN-1:0]) << 1)))
      else $error("shift add sum wrong");

   a_sext_half_out: assert property (@(posedge clk) disable iff (!rstn)
      $past(req.valid && req.op == OP_SIGN_EXT_HALF) |->
      rsp.result[XLEN-1:0] == XLEN'($signed($past(req.first_source[15:0]))))
      else $error("halfword sign extension wrong");

   a_shift1_add_uw: assert property (@(posedge clk) disable iff (!rstn)
      $past(req.valid && req.op == OP_SHIFT1_ADD_UW) && XLEN == 64 |->
      rsp.result == $past(req.second_source) + {31'h0, $past(req.first_source[31:0]), 1'b0})
      else $error("unsigned word shift add wrong");

   a_rotr_imm_reserved: assert property (@(posedge clk) disable iff (!rstn)
      $past(req.valid && req.op == OP_ROTR_IMM) |->
      rsp.illegal == (XLEN == 32 && $past(req.imm[IMM_BITS-1])))
      else $error("immediate rotate reserved check wrong");

   a_word_rot_zero: assert property (@(posedge clk) disable iff (!rstn)
      $past(req.valid && (req.op == OP_ROTL_WORD || req.op == OP_ROTR_WORD) && req.second_source[4:0] == 5'h00)
      && XLEN == 64 |-> rsp.result == {{32{$past(req.first_source[31])}}, $past(req.first_source[31:0])})
      else $error("word zero rotate changed value");

   a_rotr_word_wrap: assert property (@(posedge clk) disable iff (!rstn)
      $past(req.valid && req.op == OP_ROTR_WORD && req.second_source[4:0] == 5'h01) && XLEN == 64 |->
      rsp.result[31] == $past(req.first_source[0]))
      else $error("word rotate right wrap wrong");

endmodule // bitmanip_rotate_pack_alu

// ### verif/operand_feed.sv
// Random request source that feeds requests to the unit, or passes on bench corner cases
module operand_feed
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic use_corner,
   input wire bitmanip_pkg::alu_req_s corner,
   output bitmanip_pkg::alu_req_s req
);
   timeunit 1ns;
   timeprecision 1ns;
   import bitmanip_pkg::*;

   integer seed = 46180;

   // ==========================================
   // Request issue
   // At most one request per cycle, either a bench corner case or a random draw that may be idle
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         req <= '0;
      end
      else if (use_corner)
      begin
         req <= corner;
      end
      else
      begin
         req.valid <= ($random(seed) % 4) != 0; // Idle cycles mixed in
         req.op <= alu_op_e'(4'($random(seed)));
         req.first_source <= {$random(seed), $random(seed)};
         req.second_source <= {$random(seed), $random(seed)};
         req.imm <= 6'($random(seed));
      end
   end
endmodule // operand_feed

// ### verif/test_bitmanip_rotate_pack_alu.sv
// Self-checking bench of the bit-manipulation unit at both widths
module test_bitmanip_rotate_pack_alu;
   timeunit 1ns;
   timeprecision 1ns;
   import bitmanip_pkg::*;

   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic use_corner = 1'b0;
   alu_req_s corner = '0;
   alu_req_s req;
   alu_req_s seen;
   alu_rsp_s rsp64;
   alu_rsp_s rsp32;
   logic armed = 1'b0;
   logic [64:0] e64;
   logic [64:0] e32;
   logic [5:0] amts [5] = '{6'h00, 6'h01, 6'h1f, 6'h20, 6'h3f};
   int fails = 0;
   int checks = 0;

   // ==========================================
   // Clock and instances
   always #5 clk = ~clk;

   operand_feed feed (.clk(clk), .rstn(rstn), .use_corner(use_corner), .corner(corner), .req(req));
   bitmanip_rotate_pack_alu #(.XLEN(64)) DUT (.clk(clk), .rstn(rstn), .req(req), .rsp(rsp64));
   bitmanip_rotate_pack_alu #(.XLEN(32)) dut32 (.clk(clk), .rstn(rstn), .req(req), .rsp(rsp32));

   // ==========================================
   // Expectation
   // Rotate the low w bits of a by s places
   function automatic logic [63:0] rot(logic [63:0] a, int s, int w, bit left);
      logic [63:0] r;
      r = '0;
      for (int j = 0; j < w; j++)
      begin
         if (left)
            r[(j + s) % w] = a[j];
         else
            r[j] = a[(j + s) % w];
      end
      return rot_done(r);
   endfunction

   function automatic logic [63:0] rot_done(logic [63:0] r);
      return r;
   endfunction

   // Illegal flag above the result, worked out for width xl
   function automatic logic [64:0] expect_rsp(alu_req_s q, int xl);
      logic [63:0] a;
      logic [63:0] b;
      logic [63:0] r;
      logic ill;
      a = q.first_source;
      b = q.second_source;
      ill = 1'b0;
      r = '0;
      case (q.op)
         OP_PACK_BYTES: r = {48'h0, b[7:0], a[7:0]};
         OP_PACK_HALVES_WORD: r = {{32{b[15]}}, b[15:0], a[15:0]};
         OP_BYTE_REVERSE:
            for (int i = 0; i < xl / 8; i++)
               r[8 * i +: 8] = a[xl - 8 - 8 * i +: 8];
         OP_BIT_REVERSE_BYTES:
            for (int j = 0; j < xl; j++)
               r[j] = a[j ^ 7];
         OP_ROTL: r = rot(a, b[5:0] % xl, xl, 1'b1);
         OP_ROTR: r = rot(a, b[5:0] % xl, xl, 1'b0);
         OP_ROTR_IMM: r = rot(a, q.imm % xl, xl, 1'b0);
         OP_ROTL_WORD: r = rot(a, b[4:0], 32, 1'b1);
         OP_ROTR_WORD: r = rot(a, b[4:0], 32, 1'b0);
         OP_ROTR_IMM_WORD: r = rot(a, q.imm[4:0], 32, 1'b0);
         OP_SIGN_EXT_BYTE: r = {{56{a[7]}}, a[7:0]};
         OP_SIGN_EXT_HALF: r = {{48{a[15]}}, a[15:0]};
         OP_SHIFT1_ADD: r = (a << 1) + b;
         OP_SHIFT1_ADD_UW: r = {31'h0, a[31:0], 1'b0} + b;
         default: ill = 1'b1;
      endcase
      if (q.op inside {OP_ROTL_WORD, OP_ROTR_WORD, OP_ROTR_IMM_WORD})
         r = {{32{r[31]}}, r[31:0]};
      if (xl == 32 && (q.op inside {OP_PACK_HALVES_WORD, OP_ROTL_WORD, OP_ROTR_WORD, OP_ROTR_IMM_WORD,
          OP_SHIFT1_ADD_UW} || (q.op == OP_ROTR_IMM && q.imm[5])))
         ill = 1'b1;
      if (xl == 32)
         r[63:32] = 32'h0;
      if (ill)
         r = '0;
      return {ill, r};
   endfunction

   // ==========================================
   // Compare and report
   task automatic check_bit(string what, logic exp, logic got);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic check_word(string what, logic [63:0] exp, logic [63:0] got);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic report_and_stop();
      $display("Counts: checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ==========================================
   // Scoreboard: answer one cycle after each sampled request
   always @(posedge clk)
   begin
      // A reset in this cycle wipes the answer just registered
      if (armed && rstn)
      begin
         e64 = expect_rsp(seen, 64);
         e32 = expect_rsp(seen, 32);
         check_bit("valid64", seen.valid, rsp64.valid);
         check_bit("valid32", seen.valid, rsp32.valid);
         if (seen.valid)
         begin
            check_bit("illegal64", e64[64], rsp64.illegal);
            check_word("result64", e64[63:0], rsp64.result);
            check_bit("illegal32", e32[64], rsp32.illegal);
            check_word("result32", e32[63:0], rsp32.result);
         end
         else
         begin
            check_word("idle64", 64'h0, rsp64.result);
            check_word("idle32", 64'h0, rsp32.result);
            check_bit("idle_illegal64", 1'b0, rsp64.illegal);
         end
      end
      armed = rstn;
      seen = req;
   end

   // ==========================================
   // Main sequence: corners on every code, random traffic, mid-run reset
   initial
   begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      for (int k = 0; k < 80; k++)
      begin
         @(posedge clk);
         use_corner <= 1'b1;
         corner <= '{valid: 1'b1, op: alu_op_e'(k[3:0]), first_source: 64'h8123_4567_89ab_cdef,
                     second_source: 64'hf0f0_f0f0_f0f0_f0c0 | 64'(amts[k / 16]), imm: amts[k / 16]};
      end
      @(posedge clk);
      use_corner <= 1'b0;
      repeat (2000) @(posedge clk);
      rstn <= 1'b0;
      @(posedge clk);
      #1;
      check_bit("reset_valid", 1'b0, rsp64.valid);
      check_word("reset_result", 64'h0, rsp64.result);
      @(posedge clk);
      rstn <= 1'b1;
      repeat (200) @(posedge clk);
      report_and_stop();
   end

   // Watchdog well beyond the expected run time
   initial
   begin
      #60000;
      fails++;
      report_and_stop();
   end
endmodule // test_bitmanip_rotate_pack_alu
